// ==== hw/chpm_cfg.svh ====
// Constants for the card host port mode decoder
`ifndef CHPM_CFG_SVH
`define CHPM_CFG_SVH
`define CHPM_CFG_BASE 11'h200
`define CHPM_REG_CCSR 11'h202
`define CHPM_CCSR_SIGCHG_BIT 4
`define CHPM_CCSR_IOIF_BIT 0
`define CHPM_TF_DATA 3'h0
`define CHPM_CTL_ALTSTAT 3'h6
`define CHPM_CTL_DEVCTL 3'h6
`define CHPM_MODE_STRAP_CYCLES 4'h4
`endif

// ==== hw/chpm_lane_steer.sv ====
// Byte lane steering for the card data bus
`timescale 1ns/100ps
module chpm_lane_steer
  import chpm_pkg::*;
(
  // Access enables, active low
  input wire logic lowLaneEnable_n,
  input wire logic highLaneEnable_n,
  input wire logic addr0,
  input wire logic diskMode,
  input wire logic tfByte,
  // Lane selection
  output logic evenLane,
  output logic oddLane,
  output logic oddToLow,
  output logic wide
);
  wire lo = !lowLaneEnable_n;
  wire hi = !highLaneEnable_n;
  // Task-file registers other than data stay on low lane only
  assign wide = diskMode ? (!tfByte && lo) : (lo && hi);
  // Outside disk mode the high enable always moves the odd byte
  assign oddLane = diskMode ? wide : (hi || (lo && addr0));
  // Even byte with low enable and A0 clear, a wide access or disk mode
  assign evenLane = lo && (diskMode || wide || !addr0);
  // Odd byte folded onto D7..D0 for 8-bit hosts
  assign oddToLow = !diskMode && lo && !hi && addr0;
endmodule : chpm_lane_steer

// ==== hw/chpm_pkg.sv ====
// Types shared by the card host port mode decoder
package chpm_pkg;
  typedef enum logic [1:0] {CHPM_MEM, CHPM_IO, CHPM_DISK} chpm_mode_t;
  // Host-side bus request
  typedef struct packed {
    logic [10:0] addr;
    logic attrSel;
    logic lowLaneEnable;
    logic highLaneEnable;
    logic taskfileSelect;
    logic controlBlockSelect;
    logic outEnable;
    logic writeEnable;
    logic ioRead;
    logic ioWrite;
  } chpm_req_t;
  // Decoded target of an access
  typedef struct packed {
    logic tfHit;
    logic [2:0] tfIndex;
    logic ctlHit;
    logic cfgHit;
    logic attrHit;
    logic commonHit;
    logic ioHit;
    logic evenLane;
    logic oddLane;
    logic oddToLow;
    logic wide;
  } chpm_sel_t;
endpackage : chpm_pkg

// ==== hw/chpm_port.sv ====
// Mode strap, decode and fixed pins of the card host port
`timescale 1ns/100ps
`include "chpm_cfg.svh"
// Functional notes
// - Output enable low at power-up selects disk
// - Configuration registers start at attribute 200h
// - Disk mode decodes only A2..A0
// - Memory/IO modes decode A10..A0 with attribute
// - Memory mode battery detect one high
// - Memory mode battery detect two high
// - IO mode speaker output held high
// - IO status change alert, gated by config
// - Both insert detects always grounded
// - High enable moves odd byte outside disk mode
// - Low enable alone picks byte by A0
// - Taskfile and control block chip selects
// - Cable select pulled up; low is master
// - Diagnostic and active lines shared handshake
// - D0 even byte LSB, D8 odd LSB
// - Taskfile bytes low lane; data 16-bit
// - Output enable reads config data in IO
module chpm_port
  import chpm_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  // Host request, active-low strobes as on pins
  input chpm_pkg::chpm_req_t req,
  // Card status sources
  input wire logic readyBusyState,
  input wire logic writeProtect,
  // Shared handshake lines, inputs
  input wire logic passDiagnosticIn,
  input wire logic driveActivePeerIn,
  input wire logic cableSelectStrap,
  // Internal driver requests for handshake lines
  input wire logic passDiagnosticAssert,
  input wire logic driveActiveAssert,
  // Configuration register write data
  input wire logic [7:0] hostWriteData,
  // Mode and decode
  output chpm_pkg::chpm_mode_t mode,
  output chpm_pkg::chpm_sel_t sel,
  output logic isMaster,
  output logic [7:0] configStatus,
  // Fixed level and alert pins
  output logic batteryDetectOne,
  output logic batteryDetectTwo,
  output logic speakerOut_n,
  output logic statusChangeAlert_n,
  output logic insertDetectA_n,
  output logic insertDetectB_n,
  // Open-drain shared lines
  output logic passDiagnosticOut,
  output logic passDiagnosticOe,
  output logic driveActiveOut,
  output logic driveActiveOe
);
  import chpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Mode strap
  logic [3:0] strapCount; // Cycles since reset release
  logic strapDone; // Mode latched, frozen until reset
  wire strapWindow = !strapDone && (strapCount == `CHPM_MODE_STRAP_CYCLES);
  logic ioConfigured; // IO interface chosen through config

  // Strap captured once after power-up reset release
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      strapCount <= 4'h0;
      strapDone <= 1'b0;
      mode <= CHPM_MEM;
    end
    else if (clkEn)
    begin
      if (!strapDone)
        strapCount <= strapCount + 4'h1;
      if (strapWindow)
      begin
        strapDone <= 1'b1;
        // Grounded output enable means disk mode
        mode <= req.outEnable ? CHPM_MEM : CHPM_DISK;
      end
      else if (strapDone && mode != CHPM_DISK)
        // Memory and IO chosen by config register
        mode <= ioConfigured ? CHPM_IO : CHPM_MEM;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire diskMode = (mode == CHPM_DISK);
  wire anyEnable = !req.lowLaneEnable || !req.highLaneEnable;
  // Only the low three bits matter in disk mode; host grounds the rest
  wire [2:0] tfIdx = req.addr[2:0];
  wire tfHitW = diskMode && !req.taskfileSelect;
  wire ctlHitW = diskMode && !req.controlBlockSelect;
  // Full eleven-bit decode with attribute select
  wire attrW = !diskMode && anyEnable && !req.attrSel;
  wire cfgW = attrW && (req.addr >= `CHPM_CFG_BASE);
  wire commonW = !diskMode && anyEnable && req.attrSel;
  wire ioW = (mode == CHPM_IO) && anyEnable && req.attrSel;
  wire evenL;
  wire oddL;
  wire oddLowL;
  wire wideL;

  // Lane steering shared with the data path.
  // In disk mode the taskfile select qualifies the lanes, since the card
  // enables are not part of the disk pinout; data index 0 goes wide.
  // Control block registers never go wide; with only that select no lane is enabled.
  chpm_lane_steer u_steer (
    .lowLaneEnable_n(diskMode ? req.taskfileSelect : req.lowLaneEnable),
    .highLaneEnable_n(req.highLaneEnable),
    .addr0(req.addr[0]),
    .diskMode(diskMode),
    .tfByte(tfIdx != `CHPM_TF_DATA || ctlHitW),
    .evenLane(evenL),
    .oddLane(oddL),
    .oddToLow(oddLowL),
    .wide(wideL)
  );

  // Registered decode; D0 is even LSB, D8 odd LSB
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      sel <= '0;
    else if (clkEn)
    begin
      sel <= '{tfHit: tfHitW, tfIndex: tfIdx, ctlHit: ctlHitW,
               cfgHit: cfgW, attrHit: attrW, commonHit: commonW,
               ioHit: ioW, evenLane: evenL, oddLane: oddL,
               oddToLow: oddLowL, wide: wideL};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and status register
  wire ccsrWrite = cfgW && !req.writeEnable && (req.addr == `CHPM_REG_CCSR);
  // Config data reads use the output-enable strobe in IO mode too
  wire cfgRead = cfgW && !req.outEnable;
  logic rdyPrev;
  logic wpPrev;
  wire statusEdge = (readyBusyState != rdyPrev) || (writeProtect != wpPrev);
  logic changed; // Sticky change seen

  // Change flag: new event wins over a clearing write
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdyPrev <= 1'b0;
      wpPrev <= 1'b0;
      changed <= 1'b0;
      configStatus <= 8'h00;
      ioConfigured <= 1'b0;
    end
    else if (clkEn)
    begin
      rdyPrev <= readyBusyState;
      wpPrev <= writeProtect;
      if (statusEdge)
        changed <= 1'b1;
      else if (ccsrWrite)
        changed <= 1'b0;
      if (ccsrWrite)
      begin
        configStatus <= hostWriteData;
        ioConfigured <= hostWriteData[`CHPM_CCSR_IOIF_BIT];
      end
      else if (cfgRead)
        configStatus <= configStatus;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fixed pins and alert
  wire alertW = (mode == CHPM_IO) && changed &&
                configStatus[`CHPM_CCSR_SIGCHG_BIT];

  // Pin levels registered so every output leaves a flop
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      batteryDetectOne <= 1'b1;
      batteryDetectTwo <= 1'b1;
      speakerOut_n <= 1'b1;
      statusChangeAlert_n <= 1'b1;
      insertDetectA_n <= 1'b0;
      insertDetectB_n <= 1'b0;
      isMaster <= 1'b0;
      passDiagnosticOut <= 1'b0;
      passDiagnosticOe <= 1'b0;
      driveActiveOut <= 1'b0;
      driveActiveOe <= 1'b0;
    end
    else if (clkEn)
    begin
      // No battery, so both detect lines stay high
      batteryDetectOne <= 1'b1;
      batteryDetectTwo <= 1'b1;
      speakerOut_n <= 1'b1;
      // Alert shares pin with battery detect one
      statusChangeAlert_n <= !alertW;
      insertDetectA_n <= 1'b0;
      insertDetectB_n <= 1'b0;
      // Strap reads high when open thanks to pull-up
      isMaster <= diskMode && !cableSelectStrap;
      passDiagnosticOut <= 1'b0;
      driveActiveOut <= 1'b0;
      passDiagnosticOe <= diskMode && passDiagnosticAssert;
      driveActiveOe <= diskMode && driveActiveAssert;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  detect_grounded_a: assert property (@(posedge clk_sys) disable iff (rst)
    !insertDetectA_n && !insertDetectB_n)
    else $error("insert detect not grounded");
  mode_frozen_a: assert property (@(posedge clk_sys) disable iff (rst)
    $past(strapDone) && $past(mode) == CHPM_DISK |-> mode == CHPM_DISK)
    else $error("disk mode changed after strap");
  strap_disk_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && strapWindow && !req.outEnable |=> mode == CHPM_DISK)
    else $error("grounded strap did not select disk mode");
  speaker_high_a: assert property (@(posedge clk_sys) disable iff (rst)
    mode == CHPM_IO |=> speakerOut_n)
    else $error("speaker output not high");
  battery_high_a: assert property (@(posedge clk_sys) disable iff (rst)
    batteryDetectOne && batteryDetectTwo)
    else $error("battery detect not high");
  alert_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && alertW |=> !statusChangeAlert_n)
    else $error("status alert missing");
  high_odd_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !diskMode && !req.highLaneEnable |=> sel.oddLane)
    else $error("high enable without odd lane");
  low_a0_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !diskMode && !req.lowLaneEnable && req.highLaneEnable
    |=> sel.oddToLow == $past(req.addr[0]))
    else $error("low enable byte choice wrong");
  tf_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && diskMode && !req.taskfileSelect
    |=> sel.tfHit && sel.tfIndex == $past(req.addr[2:0]))
    else $error("taskfile select decode wrong");
  master_strap_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && diskMode && !cableSelectStrap |=> isMaster)
    else $error("grounded cable select not master");

  ////////////////////////////////////////////////////////////////////////////
  // Assertions on decode separation, config access and shared lines
  // Second detect pin grounded on its own
  insert_b_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    !insertDetectB_n)
    else $error("second insert detect not grounded");

  // Disk mode never reports memory or IO space hits
  disk_no_attr_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && diskMode |=> !sel.attrHit && !sel.commonHit && !sel.ioHit)
    else $error("memory space hit in disk mode");

  // Memory and IO modes never report taskfile hits
  mem_no_tf_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !diskMode |=> !sel.tfHit && !sel.ctlHit)
    else $error("taskfile hit outside disk mode");

  // Second chip select reaches the control block
  ctl_select_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && diskMode && !req.controlBlockSelect |=> sel.ctlHit)
    else $error("control block select missed");

  // Taskfile registers other than data stay byte-wide
  tf_narrow_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && diskMode && !req.taskfileSelect && req.controlBlockSelect &&
    req.addr[2:0] != 3'h0 |=> !sel.wide)
    else $error("taskfile register access went wide");

  // Output-enable read of config space is decoded as attribute config
  cfg_read_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && cfgRead |=> sel.cfgHit && sel.attrHit)
    else $error("config read not decoded");

  // Attribute bytes below the config base are not config hits
  cfg_base_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && attrW && req.addr < `CHPM_CFG_BASE |=> !sel.cfgHit)
    else $error("config hit below base");

  // Config write lands in the status register
  ccsr_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && ccsrWrite |=> configStatus == $past(hostWriteData))
    else $error("config write lost");

  // Any status change sets the sticky flag, even against a clear
  change_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && statusEdge |=> changed)
    else $error("status change not latched");

  // Alert stays quiet outside IO mode
  alert_mode_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && mode != CHPM_IO |=> statusChangeAlert_n)
    else $error("alert outside IO mode");

  // Open cable select reads high, so the card is slave
  slave_open_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && cableSelectStrap |=> !isMaster)
    else $error("open cable select not slave");

  // Shared lines are released outside disk mode
  diag_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !diskMode |=> !passDiagnosticOe && !driveActiveOe)
    else $error("shared line driven outside disk mode");

  // Shared lines only ever pull low
  drive_low_a: assert property (@(posedge clk_sys) disable iff (rst)
    !passDiagnosticOut && !driveActiveOut)
    else $error("shared line driven high");

  // Both enables give a full word on both lanes
  word_lanes_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !diskMode && !req.lowLaneEnable && !req.highLaneEnable
    |=> sel.wide && sel.evenLane && sel.oddLane)
    else $error("word access lanes wrong");

  // Strap counter never moves once the mode is latched
  strap_stop_a: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && strapDone |=> strapDone && strapCount == $past(strapCount))
    else $error("strap sampling restarted");
endmodule : chpm_port

// ==== verif/card_host_port_mode_decode_tb.sv ====
// Self-checking bench for the card host port mode decoder
`timescale 1ns/100ps
`include "chpm_cfg.svh"
module card_host_port_mode_decode_tb;
  import chpm_pkg::*;
  // Stimulus side
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic diskHost = 1'b0;
  logic rbs = 1'b0, wp = 1'b0, cable_select_strap = 1'b0, pdA = 1'b0, daA = 1'b0;
  logic [7:0] wdata = 8'h00;
  // Observed side
  chpm_req_t req;
  chpm_mode_t mode;
  chpm_sel_t sel;
  logic isMaster, bdOne, bdTwo, spkN, alertN, cdAN, cdBN;
  logic pdOut, pdOe, daOut, daOe;
  logic [7:0] cfgStat;
  int fails = 0;
  int checksDone = 0;

  always #25 clk_sys = ~clk_sys;

  chpm_host_model u_chpm_host_model (.diskHost(diskHost), .req(req));

  chpm_port u_chpm_port (.clk_sys(clk_sys), .rst(rst), .clkEn(1'b1),
    .req(req), .readyBusyState(rbs), .writeProtect(wp),
    .passDiagnosticIn(1'b1), .driveActivePeerIn(1'b1),
    .cableSelectStrap(cable_select_strap), .passDiagnosticAssert(pdA),
    .driveActiveAssert(daA), .hostWriteData(wdata), .mode(mode),
    .sel(sel), .isMaster(isMaster), .configStatus(cfgStat),
    .batteryDetectOne(bdOne), .batteryDetectTwo(bdTwo),
    .speakerOut_n(spkN), .statusChangeAlert_n(alertN),
    .insertDetectA_n(cdAN), .insertDetectB_n(cdBN),
    .passDiagnosticOut(pdOut), .passDiagnosticOe(pdOe),
    .driveActiveOut(daOut), .driveActiveOe(daOe));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, shared by sequence and watchdog
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Compare one flag
  task automatic chk_bit(input logic got, input logic exp);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_bit

  // Compare a byte-wide value
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  // Wait edges; drive just after, always by the same delay
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  // Power cycle with the strap held well past its sampling edge
  task automatic power_up(input logic disk);
    rst = 1'b1;
    diskHost = disk;
    u_chpm_host_model.idle();
    cyc(20);
    rst = 1'b0;
    cyc(10);
  endtask : power_up

  // Word access needs both enables
  function automatic logic exp_wide(input logic le, input logic he);
    return !le && !he;
  endfunction : exp_wide

  // Odd byte steered to low lane: low enable only, A0 set
  function automatic logic exp_odd_low(input logic le, he, a0);
    return !le && he && a0;
  endfunction : exp_odd_low

  ////////////////////////////////////////////////////////////////////////
  // Watchdog, about fifteen times the expected run length
  initial
  begin
    #(2000 * 50);
    fails++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    logic [10:0] a;
    logic [1:0] en;
    void'($urandom(29));
    power_up(1'b0);
    chk_val({6'h00, mode}, {6'h00, CHPM_MEM});
    chk_bit(bdOne, 1'b1);
    chk_bit(bdTwo, 1'b1);
    chk_bit(cdAN, 1'b0);
    chk_bit(cdBN, 1'b0);
    // Random lane steering; wide words only on even addresses
    repeat (40)
    begin
      a = 11'($urandom);
      en = 2'($urandom);
      if (en == 2'b00)
        a[0] = 1'b0;
      u_chpm_host_model.put(a, {1'b1, en, 4'hF});
      cyc(1);
      chk_bit(sel.wide, exp_wide(en[1], en[0]));
      chk_bit(sel.oddToLow, exp_odd_low(en[1], en[0], a[0]));
      if (!en[0])
        chk_bit(sel.oddLane, 1'b1);
      chk_bit(sel.evenLane, !en[1] && (!en[0] || !a[0]));
      chk_bit(sel.commonHit, en != 2'b11);
    end
    // Config read with output enable, then switch to I/O
    u_chpm_host_model.put(11'h200, 7'b0011101);
    cyc(1);
    chk_bit(sel.cfgHit, 1'b1);
    chk_bit(sel.attrHit, 1'b1);
    wdata = 8'h11;
    u_chpm_host_model.put(`CHPM_REG_CCSR, 7'b0011110);
    cyc(1);
    chk_val(cfgStat, 8'h11);
    u_chpm_host_model.idle();
    cyc(1);
    chk_val({6'h00, mode}, {6'h00, CHPM_IO});
    chk_bit(spkN, 1'b1);
    chk_bit(alertN, 1'b1);
    rbs = 1'b1;
    cyc(3);
    chk_bit(alertN, 1'b0);
    // Alert disabled: write clears flag, a new change stays silent
    wdata = 8'h01;
    u_chpm_host_model.put(`CHPM_REG_CCSR, 7'b0011110);
    cyc(1);
    u_chpm_host_model.idle();
    wp = 1'b1;
    cyc(3);
    chk_bit(alertN, 1'b1);
    // Disk mode, cable select grounded
    power_up(1'b1);
    chk_val({6'h00, mode}, {6'h00, CHPM_DISK});
    chk_bit(isMaster, 1'b1);
    chk_bit(cdAN, 1'b0);
    repeat (20)
    begin
      a = 11'($urandom);
      u_chpm_host_model.put(a, 7'b1110111);
      cyc(1);
      chk_bit(sel.tfHit, 1'b1);
      chk_val({5'h00, sel.tfIndex}, {5'h00, a[2:0]});
      chk_bit(sel.wide, a[2:0] == 3'h0);
      chk_bit(sel.commonHit, 1'b0);
    end
    u_chpm_host_model.put(11'h006, 7'b1111011);
    cyc(1);
    chk_bit(sel.ctlHit, 1'b1);
    chk_bit(sel.tfHit, 1'b0);
    chk_val({6'h00, mode}, {6'h00, CHPM_DISK});
    // Shared handshake lines
    pdA = 1'b1;
    daA = 1'b1;
    cyc(2);
    chk_bit(pdOe, 1'b1);
    chk_bit(pdOut, 1'b0);
    chk_bit(daOe, 1'b1);
    chk_bit(daOut, 1'b0);
    pdA = 1'b0;
    cable_select_strap = 1'b1;
    cyc(2);
    chk_bit(pdOe, 1'b0);
    chk_bit(isMaster, 1'b0);
    end_of_test();
  end
endmodule : card_host_port_mode_decode_tb

// ==== verif/chpm_host_model.sv ====
// Host bus model that drives the card request pins
`timescale 1ns/100ps
module chpm_host_model
  import chpm_pkg::*;
(
  // Strap choice for the next power-up
  input wire logic diskHost,
  // Pins toward the card, active low strobes
  output chpm_pkg::chpm_req_t req
);
  ////////////////////////////////////////////////////////////////////////
  // Idle bus; output enable stays at the strap level so mode is stable
  task automatic idle();
    req = '1;
    req.addr = 11'h000;
    req.outEnable = !diskHost;
  endtask : idle

  // One request, held by the caller until the sampling edge
  // Strobe order: attr, low, high, taskfile, control, read, write
  task automatic put(input logic [10:0] a, input logic [6:0] strb);
    req.addr = diskHost ? {8'h00, a[2:0]} : a;
    req.attrSel = strb[6];
    req.lowLaneEnable = strb[5];
    req.highLaneEnable = strb[4];
    req.taskfileSelect = strb[3];
    req.controlBlockSelect = strb[2];
    req.outEnable = strb[1];
    req.writeEnable = strb[0];
  endtask : put

  // Bus idle from time zero
  initial idle();
endmodule : chpm_host_model
